// [verilog/pts_pkg.sv]
/*
 package of the port traffic statistics block: sizes, counter slots,
 length limits, interval codes, timing constants and event carriers.
 assumes every event comes from mac logic on clk_sys.
*/
package pts_pkg;

    // ------------------------------------------------
    // sizes
    // ------------------------------------------------
    localparam int NPORT   = 4;
    localparam int NCNT    = 27;
    localparam int CW      = 32;
    localparam int LW      = 16;

    // ------------------------------------------------
    // counter slots
    // ------------------------------------------------
    localparam int C_CRC   = 0;
    localparam int C_OVR   = 1;
    localparam int C_FRAG  = 2;
    localparam int C_JAB   = 3;
    localparam int C_LATE  = 4;
    localparam int C_MACE  = 5;
    localparam int C_DROP  = 6;
    localparam int C_UNDER = 7;
    localparam int C_COLL  = 8;
    localparam int C_HIST  = 9;
    localparam int C_RXGF  = 15;
    localparam int C_RXGB  = 16;
    localparam int C_TXGF  = 17;
    localparam int C_TXGB  = 18;
    localparam int C_RXAF  = 19;
    localparam int C_RXAB  = 20;
    localparam int C_UNIRX = 21;
    localparam int C_UNITX = 22;
    localparam int C_MULRX = 23;
    localparam int C_MULTX = 24;
    localparam int C_BCRX  = 25;
    localparam int C_BCTX  = 26;
    localparam logic [4:0] SEL_TOTERR = 5'h1b;

    // ------------------------------------------------
    // frame limits and histogram edges
    // ------------------------------------------------
    localparam logic [LW-1:0] MIN_LEN   = 16'h0040;
    localparam logic [LW-1:0] MAX_LEN   = 16'h0600;
    localparam logic [LW-1:0] LATE_BYTE = 16'h0040;
    localparam logic [LW-1:0] B127      = 16'h007f;
    localparam logic [LW-1:0] B255      = 16'h00ff;
    localparam logic [LW-1:0] B511      = 16'h01ff;
    localparam logic [LW-1:0] B1023     = 16'h03ff;

    // ------------------------------------------------
    // timing
    // ------------------------------------------------
    localparam longint CLK_HZ      = 50000000;
    localparam longint SEC_TIME_S  = 1;
    localparam longint SEC_CYC_DEF = CLK_HZ * SEC_TIME_S;
    localparam logic [5:0] IV5_S   = 6'h05;
    localparam logic [5:0] IV15_S  = 6'h0f;
    localparam logic [5:0] IV30_S  = 6'h1e;
    localparam int IV1_MIN         = 1;
    localparam logic [5:0] IV60_S  = 6'(IV1_MIN * 60);
    localparam logic [6:0] PCT_MAX = 7'h64;

    // interval select codes
    typedef enum logic [2:0] {
        IV_5S, IV_15S, IV_30S, IV_1MIN, IV_SUSPEND
    } pts_ival_t;

    // link speed codes
    typedef enum logic [1:0] {
        SPD_DOWN, SPD_10, SPD_100, SPD_1000
    } pts_speed_t;

    // ------------------------------------------------
    // carriers
    // ------------------------------------------------
    typedef struct packed {
        logic          valid;
        logic [LW-1:0] len;
        logic          fcsOk;
        logic          alignErr;
        logic          macErr;
        logic          dropped;
        logic [47:0]   dstMac;
        logic [47:0]   srcMac;
    } pts_rx_evt_t;

    typedef struct packed {
        logic          valid;
        logic [LW-1:0] len;
        logic          good;
        logic [47:0]   dstMac;
    } pts_tx_evt_t;

    typedef struct packed {
        logic          valid;
        logic [LW-1:0] byteNum;
    } pts_col_evt_t;

endpackage

// [verilog/pts_port_stats.sv]
/*
 port traffic statistics: per-port counters, length histogram,
 error counts, last source address and utilisation.
 assumes one-cycle event pulses from mac logic on clk_sys, and a
 management agent that reads counters through the read port.
*/
`timescale 1ns/10ps

module pts_port_stats
    import pts_pkg::*;
#(
    parameter longint SEC_CYCLES = SEC_CYC_DEF
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    // frame events
    input  wire pts_rx_evt_t  [NPORT-1:0] rxEvt,
    input  wire pts_tx_evt_t  [NPORT-1:0] txEvt,
    input  wire pts_col_evt_t [NPORT-1:0] colEvt,
    input  wire pts_speed_t   [NPORT-1:0] linkSpeed,
    // management control
    input  wire logic         [NPORT-1:0] clrMask,
    input  wire logic                     clrReq,
    input  wire pts_ival_t                ivalSel,
    // counter read
    input  wire logic                     rdReq,
    input  wire logic         [1:0]       rdPort,
    input  wire logic         [4:0]       rdSel,
    output logic              [CW-1:0]    rdData,
    output logic                          rdValid,
    // live status
    output logic [NPORT-1:0][47:0]        lastSrcMac,
    output logic [NPORT-1:0][6:0]         utilPct
);

    // ------------------------------------------------
    // bytes that make one percent, per second
    // ------------------------------------------------
    // kept at least one so a shortened second cannot stall the
    // percent stepper
    localparam longint P10   = 10 * 1250 * SEC_CYCLES / CLK_HZ;
    localparam longint P100  = 100 * 1250 * SEC_CYCLES / CLK_HZ;
    localparam longint P1000 = 1000 * 1250 * SEC_CYCLES / CLK_HZ;
    localparam logic [23:0] PCT10   = (P10 < 1) ? 24'h1 : 24'(P10);
    localparam logic [23:0] PCT100  = (P100 < 1) ? 24'h1 : 24'(P100);
    localparam logic [23:0] PCT1000 = (P1000 < 1) ? 24'h1 : 24'(P1000);
    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

    // ------------------------------------------------
    // state
    // ------------------------------------------------
    typedef struct packed {
        logic [NPORT-1:0][NCNT-1:0][CW-1:0] cnt;
        logic [NPORT-1:0][47:0]             srcMac;
        logic [NPORT-1:0][6:0]              pct;
        logic [NPORT-1:0][6:0]              util;
        logic [NPORT-1:0][31:0]             resid;
        logic [31:0]                        cyc;
        logic [5:0]                         secs;
        logic [CW-1:0]                      rdData;
        logic                               rdValid;
    } pts_state_t;

    pts_state_t st_r;
    pts_state_t st_nxt;

    // ------------------------------------------------
    // decoders
    // ------------------------------------------------
    // destination class, one-hot: bit 0 unicast, bit 1 multicast, bit 2 broadcast
    function automatic logic [2:0] dstClass(input logic [47:0] mac);
        logic [2:0] c;
        c = 3'h0;
        if (mac == 48'hffffffffffff) begin
            c = 3'h4;
        end else if (mac[40]) begin
            c = 3'h2;
        end else begin
            c = 3'h1;
        end
        return c;
    endfunction

    // length histogram bin, one-hot; zero below MIN_LEN or above MAX_LEN
    function automatic logic [5:0] lenBin(input logic [LW-1:0] len);
        logic [5:0] b;
        b = 6'h00;
        if (len == MIN_LEN) begin
            b = 6'h01;
        end else if (len > MIN_LEN && len <= B127) begin
            b = 6'h02;
        end else if (len > B127 && len <= B255) begin
            b = 6'h04;
        end else if (len > B255 && len <= B511) begin
            b = 6'h08;
        end else if (len > B511 && len <= B1023) begin
            b = 6'h10;
        end else if (len > B1023 && len <= MAX_LEN) begin
            b = 6'h20;
        end
        return b;
    endfunction

    // seconds in the chosen interval
    function automatic logic [5:0] ivalSecs(input pts_ival_t s);
        logic [5:0] v;
        v = IV5_S;
        case (s)
            IV_15S:  v = IV15_S;
            IV_30S:  v = IV30_S;
            IV_1MIN: v = IV60_S;
            default: v = IV5_S;
        endcase
        return v;
    endfunction

    // ------------------------------------------------
    // next state
    // ------------------------------------------------
    always_comb begin
        logic [NCNT-1:0][LW-1:0] inc;
        logic [2:0]              rxCls;
        logic [2:0]              txCls;
        logic [5:0]              bin;
        logic                    rxOn;
        logic                    rxGood;
        logic                    txGood;
        logic                    short;
        logic                    long;
        logic                    ivalEnd;
        logic [5:0]              ivSecs;
        logic [23:0]             perSec;
        logic [31:0]             onePct;
        logic [16:0]             add;
        logic [32:0]             sum;
        logic [CW-1:0]           base;
        logic [CW-1:0]           errSum;
        inc     = '0;
        rxCls   = 3'h0;
        txCls   = 3'h0;
        bin     = 6'h00;
        rxOn    = 1'b0;
        rxGood  = 1'b0;
        txGood  = 1'b0;
        short   = 1'b0;
        long    = 1'b0;
        ivalEnd = 1'b0;
        ivSecs  = ivalSecs(ivalSel);
        perSec  = 24'h0;
        onePct  = 32'h0;
        add     = 17'h0;
        sum     = 33'h0;
        base    = '0;
        errSum  = '0;
        st_nxt  = st_r;
        st_nxt.rdValid = 1'b0;

        // interval timer stands still while suspended
        if (ivalSel != IV_SUSPEND) begin
            if (st_r.cyc >= SEC_LAST) begin
                st_nxt.cyc = 32'h0;
                if (st_r.secs >= ivSecs - 6'h01) begin
                    st_nxt.secs = 6'h00;
                    ivalEnd     = 1'b1;
                end else begin
                    st_nxt.secs = st_r.secs + 6'h01;
                end
            end else begin
                st_nxt.cyc = st_r.cyc + 32'h1;
            end
        end

        for (int p = 0; p < NPORT; p++) begin
            inc    = '0;
            rxOn   = rxEvt[p].valid;
            rxGood = rxEvt[p].fcsOk & ~rxEvt[p].alignErr & ~rxEvt[p].macErr;
            txGood = txEvt[p].valid & txEvt[p].good;
            short  = rxEvt[p].len < MIN_LEN;
            long   = rxEvt[p].len > MAX_LEN;
            rxCls  = dstClass(rxEvt[p].dstMac);
            txCls  = dstClass(txEvt[p].dstMac);
            bin    = lenBin(rxEvt[p].len);

            // ---- receive side ----
            if (rxOn) begin
                inc[C_CRC]   = {15'h0, ~rxEvt[p].fcsOk};
                inc[C_OVR]   = {15'h0, rxEvt[p].fcsOk & long};
                inc[C_FRAG]  = {15'h0, short & (rxEvt[p].alignErr | ~rxEvt[p].fcsOk)};
                inc[C_JAB]   = {15'h0, long & (rxEvt[p].alignErr | ~rxEvt[p].fcsOk)};
                inc[C_UNDER] = {15'h0, short & rxEvt[p].fcsOk};
                inc[C_DROP]  = {15'h0, rxEvt[p].dropped};
                inc[C_MACE]  = {15'h0, rxEvt[p].macErr};
                inc[C_RXAF]  = 16'h0001;
                inc[C_RXAB]  = rxEvt[p].len;
                st_nxt.srcMac[p] = rxEvt[p].srcMac;
                for (int h = 0; h < 6; h++) begin
                    inc[C_HIST+h] = {15'h0, bin[h]};
                end
                // dropped frames stay in the good counts
                if (rxGood) begin
                    inc[C_RXGB]  = rxEvt[p].len;
                    inc[C_RXGF]  = 16'h0001;
                    inc[C_UNIRX] = {15'h0, rxCls[0]};
                    inc[C_MULRX] = {15'h0, rxCls[1]};
                    inc[C_BCRX]  = {15'h0, rxCls[2]};
                end
            end

            // ---- transmit side ----
            if (txGood) begin
                inc[C_TXGB]  = txEvt[p].len;
                inc[C_TXGF]  = 16'h0001;
                inc[C_UNITX] = {15'h0, txCls[0]};
                inc[C_MULTX] = {15'h0, txCls[1]};
                inc[C_BCTX]  = {15'h0, txCls[2]};
            end

            // ---- collisions ----
            if (colEvt[p].valid) begin
                inc[C_COLL] = 16'h0001;
                inc[C_LATE] = {15'h0, colEvt[p].byteNum >= LATE_BYTE};
            end

            // all slots of one port move on the same edge; an event in
            // the clearing cycle survives the clear
            for (int c = 0; c < NCNT; c++) begin
                base = st_r.cnt[p][c];
                if (clrReq && clrMask[p] && c != C_DROP) begin
                    base = '0;
                end
                st_nxt.cnt[p][c] = base + {16'h0000, inc[c]};
            end

            // ---- utilisation stepper ----
            case (linkSpeed[p])
                SPD_10:   perSec = PCT10;
                SPD_100:  perSec = PCT100;
                SPD_1000: perSec = PCT1000;
                default:  perSec = 24'h0;
            endcase
            onePct = {8'h00, perSec} * {26'h0, ivSecs};
            add = {1'b0, (rxOn && rxGood) ? rxEvt[p].len : 16'h0}
                + {1'b0, txGood ? txEvt[p].len : 16'h0};
            sum = {1'b0, st_r.resid[p]} + {16'h0, add};
            // one step per cycle at most; full duplex may saturate
            if (ivalSel != IV_SUSPEND && onePct != 32'h0) begin
                if (sum >= {1'b0, onePct}) begin
                    st_nxt.resid[p] = 32'(sum - {1'b0, onePct});
                    if (st_r.pct[p] < PCT_MAX) begin
                        st_nxt.pct[p] = st_r.pct[p] + 7'h01;
                    end
                end else begin
                    st_nxt.resid[p] = sum[31:0];
                end
            end
            if (ivalEnd) begin
                st_nxt.util[p]  = (onePct == 32'h0) ? 7'h00 : st_nxt.pct[p];
                st_nxt.pct[p]   = 7'h00;
                st_nxt.resid[p] = 32'h0;
            end
        end

        // ---- read port ----
        if (rdReq) begin
            st_nxt.rdValid = 1'b1;
            st_nxt.rdData  = '0;
            if (rdSel == SEL_TOTERR) begin
                for (int e = C_CRC; e <= C_UNDER; e++) begin
                    errSum = errSum + st_r.cnt[rdPort][e];
                end
                st_nxt.rdData = errSum;
            end else if (rdSel < 5'(NCNT)) begin
                st_nxt.rdData = st_r.cnt[rdPort][rdSel];
            end
        end
    end

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------
    // outputs
    // ------------------------------------------------
    assign rdData     = st_r.rdData;
    assign rdValid    = st_r.rdValid;
    assign lastSrcMac = st_r.srcMac;
    assign utilPct    = st_r.util;

endmodule

// [testbench/pts_stats_properties.sv]
/*
 checker of the port traffic statistics block: read port and live status.
 assumes it is bound onto pts_port_stats, one clock domain.
*/
`timescale 1ns/10ps

module pts_stats_properties
    import pts_pkg::*;
#(
    parameter longint SEC_CYCLES = SEC_CYC_DEF
) (
    // clock, reset and events
    input wire logic                     clk_sys,
    input wire logic                     rst,
    input wire pts_rx_evt_t  [NPORT-1:0] rxEvt,
    input wire pts_col_evt_t [NPORT-1:0] colEvt,
    // management side
    input wire logic                     clrReq,
    input wire pts_ival_t                ivalSel,
    input wire logic                     rdReq,
    input wire logic         [4:0]       rdSel,
    input wire logic         [CW-1:0]    rdData,
    input wire logic                     rdValid,
    input wire logic [NPORT-1:0][47:0]   lastSrcMac,
    input wire logic [NPORT-1:0][6:0]    utilPct
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    rd_answer_a: assert property (rdReq |=> rdValid)
        else $error("read request not answered");
    rd_idle_a: assert property (!rdReq |=> !rdValid)
        else $error("answer without read request");
    rd_hold_a: assert property (!rdValid |-> $stable(rdData))
        else $error("read data moved between reads");
    bad_sel_a: assert property (rdReq && rdSel > SEL_TOTERR |=> rdData == '0)
        else $error("unknown slot read not zero");
    src_track_a: assert property (rxEvt[0].valid |=> lastSrcMac[0] == $past(rxEvt[0].srcMac))
        else $error("last source address not taken");
    src_hold_a: assert property (!rxEvt[1].valid |=> $stable(lastSrcMac[1]))
        else $error("last source address moved without frame");
    util_max_a: assert property (utilPct[2] <= PCT_MAX)
        else $error("utilisation above full scale");
    util_frozen_a: assert property ((ivalSel == IV_SUSPEND) [*3] |-> $stable(utilPct))
        else $error("utilisation moved while suspended");

    cover property (rdReq && rdSel == SEL_TOTERR);
    cover property (clrReq);
    cover property (colEvt[0].valid && colEvt[0].byteNum >= LATE_BYTE);
endmodule

bind pts_port_stats pts_stats_properties #(.SEC_CYCLES(SEC_CYCLES)) u_pts_stats_properties (
    .clk_sys(clk_sys), .rst(rst), .rxEvt(rxEvt), .colEvt(colEvt), .clrReq(clrReq),
    .ivalSel(ivalSel), .rdReq(rdReq), .rdSel(rdSel), .rdData(rdData), .rdValid(rdValid),
    .lastSrcMac(lastSrcMac), .utilPct(utilPct)
);

// [testbench/pts_mac_partner.sv]
/*
 mac side model: turns bench requests into one-cycle frame events.
 assumes the bench holds a request valid for exactly the cycles wanted.
*/
`timescale 1ns/10ps

module pts_mac_partner
    import pts_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    // requests from the bench
    input  wire pts_rx_evt_t  [NPORT-1:0] rxReq,
    input  wire pts_tx_evt_t  [NPORT-1:0] txReq,
    input  wire pts_col_evt_t [NPORT-1:0] colReq,
    // events towards the block
    output pts_rx_evt_t       [NPORT-1:0] rxEvt,
    output pts_tx_evt_t       [NPORT-1:0] txEvt,
    output pts_col_evt_t      [NPORT-1:0] colEvt
);
    // qualifiers scramble between pulses, so stale values cannot be relied on
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxEvt <= '0;
            txEvt <= '0;
            colEvt <= '0;
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                rxEvt[i] <= rxReq[i].valid ? rxReq[i] : {1'h0, ~rxEvt[i][$bits(pts_rx_evt_t)-2:0]};
                txEvt[i] <= txReq[i].valid ? txReq[i] : {1'h0, ~txEvt[i][$bits(pts_tx_evt_t)-2:0]};
                colEvt[i] <= colReq[i].valid ? colReq[i] : {1'h0, ~colEvt[i][$bits(pts_col_evt_t)-2:0]};
            end
        end
    end
endmodule

// [testbench/tb_top.sv]
/*
 testbench of the port traffic statistics block: classification, clear, utilisation.
 assumes SEC_CYCLES shortened to 100 so that a second lasts 100 cycles.
*/
`timescale 1ns/10ps

module tb_top;
    import pts_pkg::*;
    localparam longint SECS = 100;
    localparam logic [47:0] UNI = 48'h0200_0000_0001;
    localparam logic [47:0] MUL = 48'h0100_5e00_0001;
    localparam logic [47:0] BC  = 48'hffff_ffff_ffff;
    localparam int LIMIT = 30000;
    logic                     clk_sys;
    logic                     rst;
    pts_rx_evt_t  [NPORT-1:0] rxReq, rxEvt;
    pts_tx_evt_t  [NPORT-1:0] txReq, txEvt;
    pts_col_evt_t [NPORT-1:0] colReq, colEvt;
    pts_speed_t   [NPORT-1:0] linkSpeed;
    logic         [NPORT-1:0] clrMask;
    logic                     clrReq;
    pts_ival_t                ivalSel;
    logic                     rdReq;
    logic         [1:0]       rdPort;
    logic         [4:0]       rdSel;
    logic         [CW-1:0]    rdData;
    logic                     rdValid;
    logic [NPORT-1:0][47:0]   lastSrcMac;
    logic [NPORT-1:0][6:0]    utilPct;
    logic         [15:0]      srcCnt;
    int                       errors, compares, cycles;

    pts_port_stats #(.SEC_CYCLES(SECS)) u_pts_port_stats (
        .clk_sys(clk_sys), .rst(rst), .rxEvt(rxEvt), .txEvt(txEvt), .colEvt(colEvt),
        .linkSpeed(linkSpeed), .clrMask(clrMask), .clrReq(clrReq), .ivalSel(ivalSel),
        .rdReq(rdReq), .rdPort(rdPort), .rdSel(rdSel), .rdData(rdData), .rdValid(rdValid),
        .lastSrcMac(lastSrcMac), .utilPct(utilPct));
    pts_mac_partner u_pts_mac_partner (
        .clk_sys(clk_sys), .rst(rst), .rxReq(rxReq), .txReq(txReq), .colReq(colReq),
        .rxEvt(rxEvt), .txEvt(txEvt), .colEvt(colEvt));

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic finish_test();
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one request per call; other ports and kinds go quiet in the same cycle
    task automatic ev(input int p, input pts_rx_evt_t r, input pts_tx_evt_t t, input pts_col_evt_t c);
        pts_rx_evt_t  [NPORT-1:0] ra;
        pts_tx_evt_t  [NPORT-1:0] ta;
        pts_col_evt_t [NPORT-1:0] ca;
        ra = '0;
        ta = '0;
        ca = '0;
        ra[p] = r;
        ta[p] = t;
        ca[p] = c;
        @(posedge clk_sys);
        rxReq <= ra;
        txReq <= ta;
        colReq <= ca;
    endtask

    task automatic rx(input int p, input logic [LW-1:0] n, input logic f, a, m, d, input logic [47:0] dst);
        srcCnt++;
        ev(p, '{1'h1, n, f, a, m, d, dst, {32'h0a0b_0c0d, srcCnt}}, '0, '0);
    endtask

    task automatic rd(input int p, input int s, output logic [CW-1:0] v);
        @(posedge clk_sys);
        rdReq <= 1'h1;
        rdPort <= 2'(p);
        rdSel <= 5'(s);
        @(posedge clk_sys);
        rdReq <= 1'h0;
        #1;
        check(48'(rdValid), 48'h1);
        v = rdData;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_classify();
        logic [CW-1:0] v;
        logic [15:0]   ex [0:26];
        // the misaligned 1600-byte frame has a valid check sequence, so it is oversize as well as jabber
        ex = '{16'h1, 16'h2, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h2, 16'h1, 16'h1, 16'h1, 16'h0,
               16'h0, 16'h1, 16'h5, 16'hd63, 16'h3, 16'h23a, 16'h8, 16'h140b, 16'h3, 16'h1, 16'h1, 16'h1,
               16'h1, 16'h1};
        rx(0, 16'h0064, 1, 0, 0, 0, UNI);
        rx(0, 16'h0028, 0, 0, 0, 0, UNI);
        rx(0, 16'h0640, 1, 0, 0, 0, UNI);
        rx(0, 16'h0640, 1, 1, 0, 0, UNI);
        rx(0, 16'h003f, 1, 0, 0, 0, UNI);
        rx(0, 16'h0040, 1, 0, 1, 0, UNI);
        rx(0, 16'h0600, 1, 0, 0, 1, BC);
        rx(0, 16'h0080, 1, 0, 0, 0, MUL);
        ev(0, '0, '{1'h1, 16'h00c8, 1'h1, UNI}, '0);
        ev(0, '0, '{1'h1, 16'h012c, 1'h1, BC}, '0);
        ev(0, '0, '{1'h1, 16'h0046, 1'h1, MUL}, '0);
        ev(0, '0, '{1'h1, 16'h01f4, 1'h0, UNI}, '0);
        ev(0, '0, '0, '{1'h1, 16'h003f});
        ev(0, '0, '0, '{1'h1, 16'h0040});
        ev(0, '0, '0, '0);
        for (int s = 0; s < 9; s++) begin
            rd(0, s, v);
            check(v, 48'(ex[s]));
        end
        for (int s = 9; s < 27; s++) begin
            rd(0, s, v);
            check(v, 48'(ex[s]));
        end
        rd(0, 27, v);
        check(v, 48'h9);
        rd(0, 28, v);
        check(v, 48'h0);
        rd(1, C_RXAF, v);
        check(v, 48'h0);
        check(lastSrcMac[0], {32'h0a0b_0c0d, srcCnt});
    endtask

    task automatic t_clear();
        logic [CW-1:0] v;
        rx(1, 16'h0064, 1, 0, 0, 0, UNI);
        rx(0, 16'h0064, 1, 0, 0, 0, UNI);
        @(posedge clk_sys);
        rxReq <= '0;
        clrReq <= 1'h1;
        clrMask <= 4'h1;
        @(posedge clk_sys);
        clrReq <= 1'h0;
        // the frame meeting the clear edge survives it, as does the drop count
        for (int s = 0; s < 27; s++) begin
            rd(0, s, v);
            if (s == C_RXGB || s == C_RXAB) begin
                check(v, 48'h64);
            end else begin
                check(v, 48'(s == C_DROP || s == C_HIST + 1 || s == C_RXGF || s == C_RXAF || s == C_UNIRX));
            end
        end
        rd(0, 27, v);
        check(v, 48'h1);
        rd(1, C_RXAF, v);
        check(v, 48'h1);
        check(lastSrcMac[1], {32'h0a0b_0c0d, srcCnt - 16'h1});
    endtask

    task automatic t_util();
        pts_rx_evt_t r;
        logic [5:0]  secs [0:3];
        secs = '{IV5_S, IV15_S, IV30_S, IV60_S};
        r = '{1'h1, 16'h0064, 1'h1, 1'h0, 1'h0, 1'h0, UNI, 48'h0};
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            ivalSel <= pts_ival_t'(k);
            rxReq <= '{r, r, '0, '0};
            repeat (int'(secs[k]) * 2 * SECS + 10) @(posedge clk_sys);
            #1;
            check(utilPct[2], 48'(PCT_MAX));
            check(utilPct[3], 48'h0);
            check(utilPct[1], 48'h0);
        end
        @(posedge clk_sys);
        rxReq <= '0;
        ivalSel <= IV_SUSPEND;
        repeat (1300) @(posedge clk_sys);
        #1;
        check(utilPct[2], 48'(PCT_MAX));
    endtask

    // ------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        rst = 1'h1;
        rxReq = '0;
        txReq = '0;
        colReq = '0;
        linkSpeed[0] = SPD_100;
        linkSpeed[1] = SPD_1000;
        linkSpeed[2] = SPD_10;
        linkSpeed[3] = SPD_DOWN;
        clrMask = '0;
        clrReq = 1'h0;
        ivalSel = IV_5S;
        rdReq = 1'h0;
        rdPort = '0;
        rdSel = '0;
        srcCnt = '0;
        errors = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        t_classify();
        t_clear();
        t_util();
        finish_test();
    end
endmodule
